// ### verilog/ubk_pkg.sv
// package: register map, fields and types of the user break unit
package ubk_pkg;

    // ----------
    // register byte addresses
    // ----------
    localparam logic [31:0] OFS_DATA_CMP_B  = 32'h0fffff90;
    localparam logic [31:0] OFS_DATA_MSK_B  = 32'h0fffff94;
    localparam logic [31:0] OFS_BRK_CTL     = 32'h0fffff98;
    localparam logic [31:0] OFS_REP_CNT     = 32'h0fffff9c;
    localparam logic [31:0] OFS_ADR_CMP_A   = 32'h0fffffb0;
    localparam logic [31:0] OFS_ADR_MSK_A   = 32'h0fffffb4;
    localparam logic [31:0] OFS_CYC_QUAL_A  = 32'h0fffffb8;
    localparam logic [31:0] OFS_BR_DST      = 32'h0fffffbc;
    localparam logic [31:0] OFS_SPC_ID_B    = 32'h0fffffe8;
    localparam logic [31:0] OFS_ADR_CMP_B   = 32'hffffffa0;
    localparam logic [31:0] OFS_ADR_MSK_B   = 32'hffffffa4;
    localparam logic [31:0] OFS_CYC_QUAL_B  = 32'hffffffa8;
    localparam logic [31:0] OFS_BR_SRC      = 32'hffffffac;
    localparam logic [31:0] OFS_SPC_ID_A    = 32'hffffffe4;

    // ----------
    // reset values
    // ----------
    localparam logic [31:0] RST_WORD = 32'h00000000;
    localparam logic [15:0] RST_HALF = 16'h0000;

    // ----------
    // break_control fields
    // ----------
    localparam int CTL_SEQ    = 0;
    localparam int CTL_PRE_A  = 1;
    localparam int CTL_PRE_B  = 2;
    localparam int CTL_REP    = 3;
    localparam int CTL_SRC_A  = 4;
    localparam int CTL_SRC_B  = 5;
    localparam int CTL_DSRC_B = 6;
    localparam int CTL_HIT_A  = 8;
    localparam int CTL_HIT_B  = 9;
    localparam logic [31:0] CTL_WR_MASK = 32'h0000037f;

    // ----------
    // cycle qualifier fields and codes
    // ----------
    localparam int Q_MST = 6;
    localparam int Q_ID  = 4;
    localparam int Q_RW  = 2;
    localparam int Q_SZ  = 0;
    localparam logic [15:0] QUAL_WR_MASK = 16'h00ff;
    localparam logic [1:0] MST_DMA  = 2'h2;
    localparam logic [1:0] SZ_ANY   = 2'h0;

    // ----------
    // sizes, counts, trace
    // ----------
    localparam int ADDRESS_SPACE_ID_W        = 8;
    localparam int REP_W         = 12;
    localparam int TRACE_DEPTH   = 8;
    localparam int TRACE_PTR_W   = 3;
    localparam int TRACE_VLD_BIT = 31;

    typedef struct packed {
        logic              valid;
        logic              dma;
        logic              fetch;
        logic              write;
        logic [1:0]        size;
        logic [ADDRESS_SPACE_ID_W-1:0] address_space_id;
    } ubk_cyc_t;

    typedef enum logic {SEQ_IDLE, SEQ_ARMED} ubk_seq_t;

endpackage

// ### verilog/ubk_top.sv
// user break unit: two break channels, repeat count, branch trace
//
// Notes on behaviour
// (RL1) channels A and B each request a break independently on a match.
// (RL2) sequential mode: A match then B match in a later cycle only.
// (RL3) address compare is 32-bit address plus address space id.
// (RL4) each address bit can be masked individually by software.
// (RL5) compared address comes from core or cache address bus.
// (RL6) data compare exists on channel B only, 32 maskable bits.
// (RL7) compared data comes from core or cache data bus.
// (RL8) match may be qualified on core cycle or dma cycle.
// (RL9) match qualified on fetch or data access, and read or write.
// (RL10) match qualified on operand size byte, word or longword.
// (RL11) satisfied conditions raise the break request to the core.
// (RL12) fetch break taken before or after the instruction, by choice.
// (RL13) repeat count reaches at most 4095 occurrences.
// (RL14) eight pairs of branch source and destination buffers.
// (RL15) power-on reset initialises registers; other resets leave them.
// (RL16) trace entries: only the valid bit is cleared by reset.
// (RL17) address mask bit 0 compares the bit, 1 ignores it.
// (RL18) master select 00 off, x1 core cycles, 10 dma cycles.
// (RL19) repeat mode counts channel B matches until the count is met.
`timescale 1ns/10ps

// ----------
// one break channel: address, space id and cycle qualification
// ----------
module ubk_chan
    import ubk_pkg::*;
(
    input  wire ubk_cyc_t          cyc,
    input  wire logic [31:0]       addr_core,
    input  wire logic [31:0]       addr_cache,
    input  wire logic              src_sel,
    input  wire logic [31:0]       cmp_addr,
    input  wire logic [31:0]       cmp_mask,
    input  wire logic [ADDRESS_SPACE_ID_W-1:0] cmp_address_space_id,
    input  wire logic [7:0]        qual,
    output      logic              hit
);
    logic [31:0] addr;
    logic [1:0]  mst;
    logic [1:0]  sz;
    logic        adr_ok;
    logic        mst_ok;
    logic        id_ok;
    logic        rw_ok;
    logic        sz_ok;

    assign addr   = src_sel ? addr_cache : addr_core;        // RL5
    assign adr_ok = (((addr ^ cmp_addr) & ~cmp_mask) == 32'h0) // RL4 RL17
                  && (cyc.address_space_id == cmp_address_space_id);                 // RL3
    assign mst    = qual[Q_MST +: 2];
    assign mst_ok = cyc.dma ? (mst == MST_DMA) : mst[0];     // RL8 RL18
    assign id_ok  = cyc.fetch ? qual[Q_ID] : qual[Q_ID+1];   // RL9
    assign rw_ok  = cyc.write ? qual[Q_RW+1] : qual[Q_RW];   // RL9
    assign sz     = qual[Q_SZ +: 2];
    assign sz_ok  = (sz == SZ_ANY) || (sz == cyc.size);      // RL10
    assign hit    = cyc.valid & adr_ok & mst_ok & id_ok
                  & rw_ok & sz_ok;
endmodule

// ----------
// top: apb register file, break sequencing, branch trace
// ----------
module ubk_top
    import ubk_pkg::*;
(
    input  wire  logic        CLK_SYS,
    input  wire  logic        SYS_RST,
    input  wire  logic        RST_MANUAL,
    input  wire  logic        PSEL,
    input  wire  logic        PENABLE,
    input  wire  logic        PWRITE,
    input  wire  logic [31:0] PADDR,
    input  wire  logic [31:0] PWDATA,
    output       logic [31:0] PRDATA,
    output       logic        PREADY,
    output       logic        PSLVERR,
    input  wire  ubk_cyc_t    BUS_CYC,
    input  wire  logic [31:0] CORE_ADDR,
    input  wire  logic [31:0] CACHE_ADDR,
    input  wire  logic [31:0] CORE_DATA,
    input  wire  logic [31:0] CACHE_DATA,
    input  wire  logic        BR_TAKEN,
    input  wire  logic [31:0] BR_SRC,
    input  wire  logic [31:0] BR_DST,
    output       logic        BREAK_REQ,
    output       logic        BREAK_PRE
);
    // ----------
    // registers
    // ----------
    logic [31:0]       data_cmp_b_ff;
    logic [31:0]       data_msk_b_ff;
    logic [31:0]       brk_ctl_ff;
    logic [15:0]       rep_cnt_ff;
    logic [31:0]       adr_cmp_a_ff;
    logic [31:0]       adr_msk_a_ff;
    logic [15:0]       cyc_qual_a_ff;
    logic [31:0]       adr_cmp_b_ff;
    logic [31:0]       adr_msk_b_ff;
    logic [15:0]       cyc_qual_b_ff;
    logic [15:0]       spc_id_a_ff;
    logic [15:0]       spc_id_b_ff;
    logic [31:0]       prdata_ff;
    logic              pready_ff;
    logic              pslverr_ff;
    logic              brk_req_ff;
    logic              brk_pre_ff;
    ubk_seq_t          seq_ff;
    ubk_seq_t          nxt_seq;
    logic [REP_W-1:0]  occ_ff;
    logic [REP_W-1:0]  nxt_occ;
    logic [30:0]       trc_src_ff [TRACE_DEPTH];
    logic [30:0]       trc_dst_ff [TRACE_DEPTH];
    logic [TRACE_DEPTH-1:0] trc_vld_ff;
    logic [TRACE_PTR_W-1:0] trc_wr_ff;
    logic [TRACE_PTR_W-1:0] trc_rd_ff;

    // ----------
    // apb access decode
    // ----------
    logic        access;
    logic        done;
    logic        wr;
    logic [31:0] rd_val;
    logic        map_ok;
    logic        pop;

    assign access = PSEL & PENABLE;
    assign done   = access & pready_ff;
    assign wr     = done & PWRITE;
    assign pop    = done & ~PWRITE & (PADDR == OFS_BR_DST);

    always_comb begin
        rd_val = 32'h0;
        map_ok = 1'b1;
        case (PADDR)
            OFS_DATA_CMP_B: rd_val = data_cmp_b_ff;
            OFS_DATA_MSK_B: rd_val = data_msk_b_ff;
            OFS_BRK_CTL:    rd_val = brk_ctl_ff;
            OFS_REP_CNT:    rd_val = {16'h0, rep_cnt_ff};
            OFS_ADR_CMP_A:  rd_val = adr_cmp_a_ff;
            OFS_ADR_MSK_A:  rd_val = adr_msk_a_ff;
            OFS_CYC_QUAL_A: rd_val = {16'h0, cyc_qual_a_ff};
            OFS_ADR_CMP_B:  rd_val = adr_cmp_b_ff;
            OFS_ADR_MSK_B:  rd_val = adr_msk_b_ff;
            OFS_CYC_QUAL_B: rd_val = {16'h0, cyc_qual_b_ff};
            OFS_SPC_ID_A:   rd_val = {16'h0, spc_id_a_ff};
            OFS_SPC_ID_B:   rd_val = {16'h0, spc_id_b_ff};
            OFS_BR_SRC:     rd_val = {trc_vld_ff[trc_rd_ff],
                                      trc_src_ff[trc_rd_ff]};
            OFS_BR_DST:     rd_val = {trc_vld_ff[trc_rd_ff],
                                      trc_dst_ff[trc_rd_ff]};
            default:        map_ok = 1'b0;
        endcase
    end

    // one wait state: answer in the second access cycle
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= RST_WORD;
        end else begin
            pready_ff  <= access & ~pready_ff;
            pslverr_ff <= access & ~pready_ff & ~map_ok;
            prdata_ff  <= (access & ~pready_ff & ~PWRITE) ? rd_val
                                                           : RST_WORD;
        end
    end

    // ----------
    // configuration registers, power-on reset only
    // ----------
    // manual reset leaves these alone: software need not reprogram them
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin                                   // RL15
            data_cmp_b_ff <= RST_WORD;
            data_msk_b_ff <= RST_WORD;
            rep_cnt_ff    <= RST_HALF;
            adr_cmp_a_ff  <= RST_WORD;
            adr_msk_a_ff  <= RST_WORD;
            cyc_qual_a_ff <= RST_HALF;
            adr_cmp_b_ff  <= RST_WORD;
            adr_msk_b_ff  <= RST_WORD;
            cyc_qual_b_ff <= RST_HALF;
            spc_id_a_ff   <= RST_HALF;
            spc_id_b_ff   <= RST_HALF;
        end else if (wr) begin
            case (PADDR)
                OFS_DATA_CMP_B: data_cmp_b_ff <= PWDATA;
                OFS_DATA_MSK_B: data_msk_b_ff <= PWDATA;
                OFS_REP_CNT:    rep_cnt_ff    <= PWDATA[15:0];
                OFS_ADR_CMP_A:  adr_cmp_a_ff  <= PWDATA;
                OFS_ADR_MSK_A:  adr_msk_a_ff  <= PWDATA;
                OFS_CYC_QUAL_A: cyc_qual_a_ff <= PWDATA[15:0]
                                               & QUAL_WR_MASK;
                OFS_ADR_CMP_B:  adr_cmp_b_ff  <= PWDATA;
                OFS_ADR_MSK_B:  adr_msk_b_ff  <= PWDATA;
                OFS_CYC_QUAL_B: cyc_qual_b_ff <= PWDATA[15:0]
                                               & QUAL_WR_MASK;
                OFS_SPC_ID_A:   spc_id_a_ff   <= PWDATA[15:0];
                OFS_SPC_ID_B:   spc_id_b_ff   <= PWDATA[15:0];
                default: ;
            endcase
        end
    end

    // ----------
    // channel compare
    // ----------
    logic        hit_a;
    logic        hit_b;
    logic [31:0] data_b;
    logic        data_ok;
    logic        evt_b;

    ubk_chan u_chan_a (                                      // RL1
        .cyc        (BUS_CYC),
        .addr_core  (CORE_ADDR),
        .addr_cache (CACHE_ADDR),
        .src_sel    (brk_ctl_ff[CTL_SRC_A]),
        .cmp_addr   (adr_cmp_a_ff),
        .cmp_mask   (adr_msk_a_ff),
        .cmp_address_space_id   (spc_id_a_ff[ADDRESS_SPACE_ID_W-1:0]),
        .qual       (cyc_qual_a_ff[7:0]),
        .hit        (hit_a)
    );

    ubk_chan u_chan_b (                                      // RL1
        .cyc        (BUS_CYC),
        .addr_core  (CORE_ADDR),
        .addr_cache (CACHE_ADDR),
        .src_sel    (brk_ctl_ff[CTL_SRC_B]),
        .cmp_addr   (adr_cmp_b_ff),
        .cmp_mask   (adr_msk_b_ff),
        .cmp_address_space_id   (spc_id_b_ff[ADDRESS_SPACE_ID_W-1:0]),
        .qual       (cyc_qual_b_ff[7:0]),
        .hit        (hit_b)
    );

    // fetches carry no operand, so data only qualifies data access
    assign data_b  = brk_ctl_ff[CTL_DSRC_B] ? CACHE_DATA
                                            : CORE_DATA;     // RL7
    assign data_ok = BUS_CYC.fetch
                   | (((data_b ^ data_cmp_b_ff)
                       & ~data_msk_b_ff) == 32'h0);          // RL6
    assign evt_b   = hit_b & data_ok;

    // ----------
    // sequencing and repeat count
    // ----------
    logic seq_mode;
    logic cand_b;
    logic fire_a;
    logic fire_b;
    logic fire;
    logic pre;

    assign seq_mode = brk_ctl_ff[CTL_SEQ];
    // an armed A from an earlier cycle lets a B in this cycle count
    assign cand_b = seq_mode ? (evt_b & (seq_ff == SEQ_ARMED))
                             : evt_b;                        // RL2
    assign fire_a = ~seq_mode & hit_a;                       // RL1

    always_comb begin
        nxt_occ = occ_ff;
        fire_b  = cand_b;
        if (brk_ctl_ff[CTL_REP] && cand_b) begin             // RL19
            // a programmed zero behaves as one
            if ((occ_ff + 12'h001) >= rep_cnt_ff[REP_W-1:0]) begin // RL13
                nxt_occ = 12'h000;
            end else begin
                nxt_occ = occ_ff + 12'h001;
                fire_b  = 1'b0;
            end
        end
    end

    always_comb begin
        nxt_seq = seq_ff;
        case (seq_ff)
            SEQ_IDLE:  if (seq_mode && hit_a) nxt_seq = SEQ_ARMED; // RL2
            SEQ_ARMED: begin
                if (!seq_mode) begin
                    nxt_seq = SEQ_IDLE;
                end else if (hit_a) begin
                    nxt_seq = SEQ_ARMED;
                end else if (cand_b) begin
                    nxt_seq = SEQ_IDLE;
                end
            end
            default:   nxt_seq = SEQ_IDLE;
        endcase
    end

    assign fire = fire_a | fire_b;
    assign pre  = BUS_CYC.fetch
                & (fire_b ? brk_ctl_ff[CTL_PRE_B]
                          : brk_ctl_ff[CTL_PRE_A]);          // RL12

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST || RST_MANUAL) begin
            seq_ff <= SEQ_IDLE;
            occ_ff <= 12'h000;
        end else begin
            seq_ff <= nxt_seq;
            occ_ff <= nxt_occ;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST || RST_MANUAL) begin
            brk_req_ff <= 1'b0;
            brk_pre_ff <= 1'b0;
        end else begin
            brk_req_ff <= fire;                              // RL11
            brk_pre_ff <= fire & pre;                        // RL12
        end
    end

    // match flags: hardware set wins over a software clear
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin                                   // RL15
            brk_ctl_ff <= RST_WORD;
        end else begin
            if (wr && (PADDR == OFS_BRK_CTL)) begin
                brk_ctl_ff <= PWDATA & CTL_WR_MASK;
            end
            if (hit_a) begin
                brk_ctl_ff[CTL_HIT_A] <= 1'b1;
            end
            if (evt_b) begin
                brk_ctl_ff[CTL_HIT_B] <= 1'b1;
            end
        end
    end

    // ----------
    // branch trace
    // ----------
    // data storage has no reset; bit 31 of each address is dropped
    always_ff @(posedge CLK_SYS) begin
        if (BR_TAKEN) begin                                  // RL14 RL16
            trc_src_ff[trc_wr_ff] <= BR_SRC[30:0];
            trc_dst_ff[trc_wr_ff] <= BR_DST[30:0];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin                                   // RL16
            trc_vld_ff <= 8'h00;
            trc_wr_ff  <= 3'h0;
            trc_rd_ff  <= 3'h0;
        end else begin
            if (pop) begin
                trc_vld_ff[trc_rd_ff] <= 1'b0;
                trc_rd_ff <= trc_rd_ff + 3'h1;
            end
            // a new entry wins over a pop of the same slot
            if (BR_TAKEN) begin                              // RL14
                trc_vld_ff[trc_wr_ff] <= 1'b1;
                trc_wr_ff <= trc_wr_ff + 3'h1;
            end
        end
    end

    // ----------
    // outputs
    // ----------
    assign PRDATA    = prdata_ff;
    assign PREADY    = pready_ff;
    assign PSLVERR   = pslverr_ff;
    assign BREAK_REQ = brk_req_ff;
    assign BREAK_PRE = brk_pre_ff;

endmodule

// ### bench/ubk_top_sva.sv
// checker: port-level properties of the user break unit
`timescale 1ns/10ps
module ubk_top_chk
    import ubk_pkg::*;
(
    input wire logic        CLK_SYS,
    input wire logic        SYS_RST,
    input wire logic        RST_MANUAL,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire ubk_cyc_t    BUS_CYC,
    input wire logic        BREAK_REQ,
    input wire logic        BREAK_PRE
);
    default clocking @(posedge CLK_SYS);
    endclocking
    default disable iff (SYS_RST);

    por_quiet_a: assert property (disable iff (1'b0)
        $fell(SYS_RST) |-> !BREAK_REQ && !BREAK_PRE && !PREADY
        && !PSLVERR && PRDATA == 32'h0) else $error("outputs not reset");
    manual_clear_a: assert property (RST_MANUAL |=> !BREAK_REQ)
        else $error("break after manual reset");
    pre_with_req_a: assert property (BREAK_PRE |-> BREAK_REQ)
        else $error("before flag without break");
    pre_fetch_a: assert property (BREAK_PRE |->
        $past(BUS_CYC.valid && BUS_CYC.fetch)) else $error("before on data");
    req_cause_a: assert property (BREAK_REQ |-> $past(BUS_CYC.valid))
        else $error("break without bus cycle");
    ready_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("ready late");
    ready_cause_a: assert property (PREADY |->
        $past(PSEL && PENABLE && !PREADY)) else $error("ready unasked");
    err_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside transfer");
endmodule

bind ubk_top ubk_top_chk ubk_top_chk_i (.CLK_SYS, .SYS_RST, .RST_MANUAL,
    .PSEL, .PENABLE, .PRDATA, .PREADY, .PSLVERR, .BUS_CYC, .BREAK_REQ,
    .BREAK_PRE);

// ### bench/ubk_core_model.sv
// far-side model: core bus cycles and taken branches
`timescale 1ns/10ps
module ubk_core_model
    import ubk_pkg::*;
(
    input  wire logic  clk,
    output ubk_cyc_t    cyc,
    output logic [31:0] core_addr,
    output logic [31:0] cache_addr,
    output logic [31:0] core_data,
    output logic [31:0] cache_data,
    output logic        br_taken,
    output logic [31:0] br_src,
    output logic [31:0] br_dst
);
    initial begin
        cyc = '0;
        {core_addr, cache_addr, core_data, cache_data} = '0;
        {br_taken, br_src, br_dst} = '0;
    end
    // idle buses flip, so a stale value can never fake a match
    task automatic idle();
        cyc.valid  <= 1'b0;
        core_addr  <= ~core_addr;
        cache_addr <= ~cache_addr;
        core_data  <= ~core_data;
        cache_data <= ~cache_data;
        br_taken   <= 1'b0;
        br_src     <= ~br_src;
        br_dst     <= ~br_dst;
    endtask
    task automatic drive(input ubk_cyc_t c, input logic [31:0] ca, xa, cd, xd);
        @(posedge clk);
        cyc        <= c;
        core_addr  <= ca;
        cache_addr <= xa;
        core_data  <= cd;
        cache_data <= xd;
        @(posedge clk);
        idle();
    endtask
    task automatic branch(input logic [31:0] s, d);
        @(posedge clk);
        br_taken <= 1'b1;
        br_src   <= s;
        br_dst   <= d;
        @(posedge clk);
        idle();
    endtask
endmodule

// ### bench/user_break_comparator_tb.sv
// self-checking bench for the user break unit
`timescale 1ns/10ps
module user_break_comparator_tb
    import ubk_pkg::*;
;
    logic        clk, rst, rst_man, psel, penable, pwrite, pready, pslverr;
    logic        br_taken, brk_req, brk_pre;
    logic [31:0] paddr, pwdata, prdata, core_addr, cache_addr;
    logic [31:0] core_data, cache_data, br_src, br_dst;
    ubk_cyc_t    cyc;
    // index order of the register model
    localparam logic [31:0] OFS [14] = '{OFS_DATA_CMP_B, OFS_DATA_MSK_B,
        OFS_BRK_CTL, OFS_REP_CNT, OFS_ADR_CMP_A, OFS_ADR_MSK_A,
        OFS_CYC_QUAL_A, OFS_BR_DST, OFS_SPC_ID_B, OFS_ADR_CMP_B,
        OFS_ADR_MSK_B, OFS_CYC_QUAL_B, OFS_BR_SRC, OFS_SPC_ID_A};
    localparam logic [31:0] WMSK [14] = '{32'hffffffff, 32'hffffffff,
        32'h0000037f, 32'h0000ffff, 32'hffffffff, 32'hffffffff,
        32'h000000ff, 32'h0, 32'h0000ffff, 32'hffffffff, 32'hffffffff,
        32'h000000ff, 32'h0, 32'h0000ffff};
    localparam int NREP [3] = '{2, 0, 4095};
    logic [31:0] rm [14];
    logic [31:0] ts [8];
    logic [31:0] td [8];
    logic        tv [8];
    integer      n_fail = 0, num_checks = 0, seed = 32'h22c6;
    integer      armed = 0, rep = 0, wp = 0, rp = 0;

    ubk_top ubk_top_i (.CLK_SYS(clk), .SYS_RST(rst), .RST_MANUAL(rst_man),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .BUS_CYC(cyc), .CORE_ADDR(core_addr),
        .CACHE_ADDR(cache_addr), .CORE_DATA(core_data),
        .CACHE_DATA(cache_data), .BR_TAKEN(br_taken), .BR_SRC(br_src),
        .BR_DST(br_dst), .BREAK_REQ(brk_req), .BREAK_PRE(brk_pre));
    ubk_core_model ubk_core_model_i (.clk(clk), .cyc(cyc),
        .core_addr(core_addr), .cache_addr(cache_addr),
        .core_data(core_data), .cache_data(cache_data),
        .br_taken(br_taken), .br_src(br_src), .br_dst(br_dst));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ----------
    // checks, bus access, model
    // ----------
    task automatic chk(input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] a, wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input int i, input logic [31:0] v);
        logic [31:0] d;
        logic        er;
        apb(1'b1, OFS[i], v, d, er);
        rm[i] = v & WMSK[i];
        chk(er, 1'b0);
    endtask
    // trace reads: source first, destination read pops the slot
    task automatic rdc(input int i);
        logic [31:0] d, e;
        logic        er;
        apb(1'b0, OFS[i], 32'h0, d, er);
        chk(er, 1'b0);
        e = rm[i];
        if (i == 7 || i == 12) begin
            e = (i == 7) ? td[rp] : ts[rp];
            e[31] = tv[rp];
            if (!tv[rp]) begin
                e[30:0] = '0;
                d[30:0] = '0;
            end
            if (i == 7) begin
                tv[rp] = 1'b0;
                rp = (rp + 1) % 8;
            end
        end
        chk(d, e);
    endtask
    function automatic logic hit(input int b, input ubk_cyc_t c,
                                 input logic [31:0] ca, xa, cd, xd);
        logic [7:0]  q;
        logic [31:0] a;
        logic        ok;
        q = rm[b ? 11 : 6][7:0];
        a = rm[2][b ? CTL_SRC_B : CTL_SRC_A] ? xa : ca;
        ok = c.valid && ((a ^ rm[b ? 9 : 4]) & ~rm[b ? 10 : 5]) == 0
            && c.address_space_id == rm[b ? 8 : 13][7:0]
            && (q[6] ? !c.dma : q[7] && c.dma)
            && (c.fetch ? q[4] : q[5]) && (c.write ? q[3] : q[2])
            && (q[1:0] == SZ_ANY || q[1:0] == c.size);
        if (b != 0 && !c.fetch)
            ok = ok && (((rm[2][CTL_DSRC_B] ? xd : cd) ^ rm[0]) & ~rm[1]) == 0;
        return ok;
    endfunction
    task automatic step(input ubk_cyc_t c, input logic [31:0] ca, xa, cd, xd);
        logic ha, hb, eb, ep, fa;
        ha = hit(0, c, ca, xa, cd, xd);
        hb = hit(1, c, ca, xa, cd, xd);
        eb = rm[2][CTL_SEQ] ? armed && hb : hb;
        if (rm[2][CTL_SEQ]) armed = ha || armed && !hb;
        if (eb && rm[2][CTL_REP]) begin
            rep++;
            eb = rep >= (rm[3][11:0] == 0 ? 1 : rm[3][11:0]);
            if (eb) rep = 0;
        end
        fa = ha && !rm[2][CTL_SEQ];
        ep = c.fetch && (eb ? rm[2][CTL_PRE_B] : fa && rm[2][CTL_PRE_A]);
        eb = eb || fa;
        if (ha) rm[2][CTL_HIT_A] = 1'b1;
        if (hb) rm[2][CTL_HIT_B] = 1'b1;
        ubk_core_model_i.drive(c, ca, xa, cd, xd);
        #1;
        chk(brk_req, eb);
        chk(brk_pre, ep);
    endtask
    task automatic mrst();
        @(posedge clk);
        rst_man <= 1'b1;
        @(posedge clk);
        rst_man <= 1'b0;
        armed = 0;
        rep = 0;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ----------
    // scenarios
    // ----------
    initial begin
        logic [31:0] d, r, a, q;
        logic        er;
        ubk_cyc_t    c;
        {rst, rst_man, psel, penable, pwrite, paddr, pwdata} = {2'b10, 67'h0};
        for (int i = 0; i < 14; i++) rm[i] = '0;
        for (int i = 0; i < 8; i++) {tv[i], ts[i], td[i]} = '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 14; i++) rdc(i);
        apb(1'b0, 32'h0fffffa0, 32'h0, d, er);
        chk({er, d}, {1'b1, 32'h0});
        for (int i = 0; i < 14; i++) wr(i, $random(seed) & ~32'h300);
        for (int i = 0; i < 14; i++) rdc(i);
        mrst();
        for (int i = 2; i < 6; i++) rdc(i);
        // every master, fetch/data and direction code, masked pages
        for (int k = 0; k < 16; k++) begin
            q = $random(seed);
            q[7:2] = {k[1:0], k[3:2], k[1:0] ^ k[3:2]};
            wr(6, q);
            wr(11, {q[1:0], q[5:2], q[7:6]});
            wr(2, $random(seed) & 32'h76);
            wr(5, k[0] ? 32'h00000fff : 32'h000003ff);
            wr(10, k[1] ? 32'hffffffff : 32'h00000fff);
            for (int i = 0; i < 14; i++)
                if (i inside {0, 1, 4, 8, 9, 13}) wr(i, $random(seed));
            for (int j = 0; j < 8; j++) begin
                r = $random(seed);
                c = r[13:0];
                c.valid = c.valid | r[12];
                if (!r[14]) c.address_space_id = r[13] ? rm[13][7:0] : rm[8][7:0];
                a = (r[15] ? rm[4] : rm[9]) ^ (r[16] ? r[31:19] : 32'h0);
                d = rm[0] ^ (r[18] ? $random(seed) : 32'h0);
                step(c, r[17] ? a : ~a, r[17] ? ~a : a,
                     r[19] ? d : ~d, r[19] ? ~d : d);
            end
            rdc(2);
        end
        // repeat count, boundary values included
        wr(2, 32'h8);
        wr(6, 32'h0);
        wr(11, 32'h68);
        wr(1, 32'hffffffff);
        c = '{1'b1, 1'b0, 1'b0, 1'b1, 2'h3, rm[8][7:0]};
        for (int n = 0; n < 3; n++) begin
            wr(3, NREP[n]);
            mrst();
            repeat (NREP[n] + 2) step(c, $random(seed), 32'h0, 32'h0,
                32'h0);
        end
        // sequential: same cycle arms only, a later B breaks
        wr(2, 32'h1);
        wr(6, 32'h68);
        wr(5, 32'h0);
        wr(4, 32'h1000);
        wr(13, rm[8]);
        mrst();
        step(c, 32'h1000, 32'h1000, 32'h0, 32'h0);
        step(c, 32'h2000, 32'h2000, 32'h0, 32'h0);
        mrst();
        step(c, 32'h2000, 32'h2000, 32'h0, 32'h0);
        // nine branches into eight pairs: oldest slot overwritten
        for (int i = 0; i < 9; i++) begin
            r = $random(seed);
            a = $random(seed);
            ubk_core_model_i.branch(r, a);
            {tv[wp], ts[wp], td[wp]} = {1'b1, r, a};
            wp = (wp + 1) % 8;
        end
        for (int i = 0; i < 9; i++) begin
            rdc(12);
            rdc(7);
        end
        conclude();
    end

    initial begin
        #400000;
        n_fail++;
        conclude();
    end
endmodule
